/* File: design/tcc_counter_capture.sv */
// module: 16-bit up/down counter with input capture behind a byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module tcc_counter_capture
   import tcc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic capture_pin,
   input wire logic capture_port_drive,
   input wire logic capture_port_value,
   input wire logic comparator_output,
   input wire logic external_tick_pin,
   input wire logic capture_irq_ack,
   input wire logic overflow_irq_ack,
   output logic capture_irq_req,
   output logic overflow_irq_req,
   output logic count_at_top,
   output logic count_at_bottom
);
   // -------------------------------------------------------------
   // mode decoding helpers
   // -------------------------------------------------------------
   // modes that hold top in the capture value register
   function automatic logic uses_capture_top(input logic [3:0] mode);
      uses_capture_top = (mode == WGM_PC_CAPTOP_A) || (mode == WGM_PC_CAPTOP_B) ||
         (mode == WGM_CTC_CAPTOP) || (mode == WGM_FAST_CAPTOP);
   endfunction

   // dual-slope modes count up then down
   function automatic logic is_dual_slope(input logic [3:0] mode);
      is_dual_slope = (mode[3:2] == 2'b00 && mode[1:0] != 2'b00) || (mode[3:2] == 2'b10 && !mode[0]);
   endfunction

   // single-slope modes that raise overflow at top rather than at max
   function automatic logic overflow_at_top(input logic [3:0] mode);
      overflow_at_top = (mode[3:2] == 2'b01 && mode[1:0] != 2'b00) || (mode == WGM_FAST_CAPTOP);
   endfunction

   function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] cap);
      if (uses_capture_top(mode))
      begin
         top_of = cap;
      end
      else
      begin
         case (mode[1:0])
            2'b01: top_of = TOP_8BIT;
            2'b10: top_of = TOP_9BIT;
            2'b11: top_of = TOP_10BIT;
            default: top_of = COUNT_MAX;
         endcase
      end
   endfunction

   // -------------------------------------------------------------
   // pin synchronisers: capture, comparator, external tick
   // -------------------------------------------------------------
   localparam int NSYNC = 3;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] pin_q;
   // port drive shows on the pin, so software can make its own edges
   assign pin_raw = {external_tick_pin, comparator_output,
      capture_port_drive ? capture_port_value : capture_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic q_r;
         logic q_nxt;
         // a change is taken only once the second and third stages agree
         always_comb
         begin
            q_nxt = (s2_r == s3_r) ? s3_r : q_r;
         end
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               q_r <= 1'b0;
            end
            else
            begin
               s1_r <= pin_raw[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               q_r <= q_nxt;
            end
         end
         assign pin_q[gi] = q_r;
      end
   endgenerate

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [7:0] ctrl_a_r, ctrl_a_nxt;
   logic [7:0] ctrl_b_r, ctrl_b_nxt;
   logic [7:0] comp_ctrl_r, comp_ctrl_nxt;
   logic [7:0] irq_mask_r, irq_mask_nxt;
   logic [7:0] temp_r, temp_nxt;
   logic [15:0] count_r, count_nxt;
   logic [15:0] capture_r, capture_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic ovf_flag_r, ovf_flag_nxt;
   logic cap_flag_r, cap_flag_nxt;
   tcc_dir_t dir_r, dir_nxt;
   logic [PRESCALE_W-1:0] pre_r, pre_nxt;
   logic ext_prev_r;
   logic edge_prev_r;

   logic [3:0] mode;
   logic [2:0] tick_sel;
   logic [15:0] top_val;
   logic tick;
   logic cap_src;
   logic cap_level;
   logic cap_event;
   logic ovf_set;
   logic wr_count_low;
   logic wr_capture_low;
   logic ovf_clear;
   logic cap_clear;

   assign mode = {ctrl_b_r[CTRL_B_WGM_HI+1:CTRL_B_WGM_HI], ctrl_a_r[CTRL_A_WGM_LO+1:CTRL_A_WGM_LO]};
   assign tick_sel = ctrl_b_r[CTRL_B_TICK_LO+2:CTRL_B_TICK_LO];
   assign top_val = top_of(mode, capture_r);

   // -------------------------------------------------------------
   // tick source select: prescaler strobes or external edges
   // -------------------------------------------------------------
   // free-running divider; every rate is a one-cycle enable, never a clock
   always_comb
   begin
      pre_nxt = pre_r + 1'b1;
      case (tick_sel)
         TICK_DIV1: tick = 1'b1;
         TICK_DIV8: tick = &pre_r[2:0];
         TICK_DIV64: tick = &pre_r[5:0];
         TICK_DIV256: tick = &pre_r[7:0];
         TICK_DIV1024: tick = &pre_r[9:0];
         TICK_EXT_FALL: tick = ext_prev_r && !pin_q[2];
         TICK_EXT_RISE: tick = !ext_prev_r && pin_q[2];
         default: tick = 1'b0;
      endcase
   end

   // -------------------------------------------------------------
   // capture path: source select, noise filter, edge detect
   // -------------------------------------------------------------
   assign cap_src = comp_ctrl_r[COMP_CAPTURE_SEL] ? pin_q[1] : pin_q[0];

   tcc_noise_filter u_filter (
      .clk(clk),
      .sys_rst(sys_rst),
      .filter_en(ctrl_b_r[CTRL_B_FILTER]),
      .sample_in(cap_src),
      .level_out(cap_level)
   );

   // the detector is muted while capture value acts as top, so top stays put
   assign cap_event = !uses_capture_top(mode) &&
      (ctrl_b_r[CTRL_B_EDGE] ? (cap_level && !edge_prev_r) : (!cap_level && edge_prev_r));

   // -------------------------------------------------------------
   // register port decode
   // -------------------------------------------------------------
   assign wr_count_low = reg_wr && reg_addr == ADDR_COUNT_LOW;
   assign wr_capture_low = reg_wr && reg_addr == ADDR_CAPTURE_LOW && uses_capture_top(mode);
   assign ovf_clear = overflow_irq_ack || (reg_wr && reg_addr == ADDR_FLAGS && reg_wdata[FLAG_OVERFLOW]);
   assign cap_clear = capture_irq_ack ||
      (reg_wr && reg_addr == ADDR_FLAGS && reg_wdata[FLAG_CAPTURE]);

   // -------------------------------------------------------------
   // next state: counter, latch, capture, flags, read data
   // -------------------------------------------------------------
   always_comb
   begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      comp_ctrl_nxt = comp_ctrl_r;
      irq_mask_nxt = irq_mask_r;
      temp_nxt = temp_r;
      count_nxt = count_r;
      capture_nxt = capture_r;
      dir_nxt = dir_r;
      rdata_nxt = BYTE_RESET;
      ovf_set = 1'b0;
      // counting on each tick, shaped by the mode
      if (tick)
      begin
         if (is_dual_slope(mode))
         begin
            if (dir_r == TCC_DIR_UP && count_r >= top_val)
            begin
               dir_nxt = TCC_DIR_DOWN;
               count_nxt = count_r - COUNT_ONE;
            end
            else if (dir_r == TCC_DIR_DOWN && count_r == COUNT_BOTTOM)
            begin
               dir_nxt = TCC_DIR_UP;
               count_nxt = count_r + COUNT_ONE;
               ovf_set = 1'b1;
            end
            else
            begin
               count_nxt = (dir_r == TCC_DIR_UP) ? count_r + COUNT_ONE : count_r - COUNT_ONE;
            end
         end
         else if (count_r == top_val)
         begin
            count_nxt = COUNT_BOTTOM;
            dir_nxt = TCC_DIR_UP;
            ovf_set = overflow_at_top(mode) || count_r == COUNT_MAX;
         end
         else
         begin
            count_nxt = count_r + COUNT_ONE;
            dir_nxt = TCC_DIR_UP;
            ovf_set = !overflow_at_top(mode) && count_r == COUNT_MAX;
         end
      end
      if (cap_event)
      begin
         capture_nxt = count_r;
      end
      // software writes; high-byte locations only ever touch the latch
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_CTRL_A: ctrl_a_nxt = reg_wdata;
            ADDR_CTRL_B: ctrl_b_nxt = reg_wdata;
            ADDR_COMP_CTRL: comp_ctrl_nxt = reg_wdata;
            ADDR_IRQ_MASK: irq_mask_nxt = reg_wdata;
            ADDR_COUNT_HIGH: temp_nxt = reg_wdata;
            ADDR_CAPTURE_HIGH: temp_nxt = reg_wdata;
            default: temp_nxt = temp_r;
         endcase
      end
      if (wr_count_low)
      begin
         count_nxt = {temp_r, reg_wdata};
      end
      if (wr_capture_low)
      begin
         capture_nxt = {temp_r, reg_wdata};
      end
      // reads; low-byte reads snapshot the upper byte into the latch
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_CTRL_A: rdata_nxt = ctrl_a_r;
            ADDR_CTRL_B: rdata_nxt = ctrl_b_r;
            ADDR_COMP_CTRL: rdata_nxt = comp_ctrl_r;
            ADDR_IRQ_MASK: rdata_nxt = irq_mask_r;
            ADDR_COUNT_LOW:
            begin
               rdata_nxt = count_r[7:0];
               temp_nxt = count_r[15:8];
            end
            ADDR_CAPTURE_LOW:
            begin
               rdata_nxt = capture_r[7:0];
               temp_nxt = capture_r[15:8];
            end
            ADDR_COUNT_HIGH: rdata_nxt = temp_r;
            ADDR_CAPTURE_HIGH: rdata_nxt = temp_r;
            ADDR_FLAGS:
            begin
               rdata_nxt = BYTE_RESET;
               rdata_nxt[FLAG_OVERFLOW] = ovf_flag_r;
               rdata_nxt[FLAG_CAPTURE] = cap_flag_r;
            end
            default: rdata_nxt = BYTE_RESET;
         endcase
      end
      // a set in the same cycle as a clear wins, so no event is lost
      ovf_flag_nxt = (ovf_flag_r && !ovf_clear) || ovf_set;
      cap_flag_nxt = (cap_flag_r && !cap_clear) || cap_event;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_a_r <= BYTE_RESET;
         ctrl_b_r <= BYTE_RESET;
         comp_ctrl_r <= BYTE_RESET;
         irq_mask_r <= BYTE_RESET;
         temp_r <= BYTE_RESET;
         count_r <= WORD_RESET;
         capture_r <= WORD_RESET;
         rdata_r <= BYTE_RESET;
         ovf_flag_r <= 1'b0;
         cap_flag_r <= 1'b0;
         dir_r <= TCC_DIR_UP;
         pre_r <= '0;
         ext_prev_r <= 1'b0;
         edge_prev_r <= 1'b0;
      end
      else
      begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         comp_ctrl_r <= comp_ctrl_nxt;
         irq_mask_r <= irq_mask_nxt;
         temp_r <= temp_nxt;
         count_r <= count_nxt;
         capture_r <= capture_nxt;
         rdata_r <= rdata_nxt;
         ovf_flag_r <= ovf_flag_nxt;
         cap_flag_r <= cap_flag_nxt;
         dir_r <= dir_nxt;
         pre_r <= pre_nxt;
         ext_prev_r <= pin_q[2];
         edge_prev_r <= cap_level;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign reg_rdata = rdata_r;
   assign capture_irq_req = cap_flag_r && irq_mask_r[FLAG_CAPTURE];
   assign overflow_irq_req = ovf_flag_r && irq_mask_r[FLAG_OVERFLOW];
   assign count_at_top = count_r == top_val;
   assign count_at_bottom = count_r == COUNT_BOTTOM;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_low_read;
      reg_rd && reg_addr == ADDR_COUNT_LOW && !reg_wr;
   endsequence
   sequence s_high_read;
      reg_rd && reg_addr == ADDR_COUNT_HIGH;
   endsequence

   count_write_a: assert property (wr_count_low |=> count_r == {$past(temp_r), $past(reg_wdata)})
      else $error("low-byte write did not load the whole counter");
   atomic_read_a: assert property (s_low_read ##1 s_high_read |=>
      reg_rdata == $past(count_r[15:8], 2)) else $error("high byte not the one latched by low read");
   latch_only_a: assert property ((reg_wr && reg_addr == ADDR_COUNT_HIGH) |=>
      temp_r == $past(reg_wdata) && ($past(tick_sel) != TICK_STOP || count_r == $past(count_r)))
      else $error("high-byte write missed the latch or reached the counter");
   stopped_hold_a: assert property ((tick_sel == TICK_STOP && !wr_count_low) |=> count_r == $past(count_r))
      else $error("stopped counter moved");
   capture_copy_a: assert property (cap_event |=> capture_r == $past(count_r) && cap_flag_r)
      else $error("capture did not copy counter and set flag");
   set_wins_a: assert property ((cap_event && cap_clear) |=> cap_flag_r)
      else $error("capture lost against a clear");
   top_mode_mute_a: assert property ((uses_capture_top(mode) && !wr_capture_low) |=>
      capture_r == $past(capture_r) && !$rose(cap_flag_r)) else $error("capture while capture value defines top");
   wrap_overflow_a: assert property ((tick && mode == WGM_NORMAL && count_r == COUNT_MAX && !wr_count_low)
      |=> ovf_flag_r && count_r == COUNT_BOTTOM) else $error("normal wrap missed overflow");
endmodule
`default_nettype wire

/* File: shared/tcc_pkg.sv */
// package: constants, register map and field layout of the 16-bit counter with capture
package tcc_pkg;
   // -------------------------------------------------------------
   // register offsets on the 4-bit byte-wide register port
   // -------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL_A = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B = 4'h1;
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
   localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
   localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h4;
   localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h5;
   localparam logic [3:0] ADDR_FLAGS = 4'h6;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
   localparam logic [3:0] ADDR_COMP_CTRL = 4'h8;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int CTRL_A_WGM_LO = 0;       // mode bits 1:0 live in control_reg_a 1:0
   localparam int CTRL_B_TICK_LO = 0;      // tick_source_select in control_reg_b 2:0
   localparam int CTRL_B_WGM_HI = 3;       // mode bits 3:2 live in control_reg_b 4:3
   localparam int CTRL_B_EDGE = 6;         // 1 = rising edge captures
   localparam int CTRL_B_FILTER = 7;       // noise_filter_enable
   localparam int FLAG_OVERFLOW = 0;
   localparam int FLAG_CAPTURE = 5;
   localparam int COMP_CAPTURE_SEL = 2;    // comparator_capture_select

   // -------------------------------------------------------------
   // reset values and counter landmarks
   // -------------------------------------------------------------
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   // -------------------------------------------------------------
   // tick sources (tick_source_select encodings)
   // -------------------------------------------------------------
   localparam logic [2:0] TICK_STOP = 3'h0;
   localparam logic [2:0] TICK_DIV1 = 3'h1;
   localparam logic [2:0] TICK_DIV8 = 3'h2;
   localparam logic [2:0] TICK_DIV64 = 3'h3;
   localparam logic [2:0] TICK_DIV256 = 3'h4;
   localparam logic [2:0] TICK_DIV1024 = 3'h5;
   localparam logic [2:0] TICK_EXT_FALL = 3'h6;
   localparam logic [2:0] TICK_EXT_RISE = 3'h7;
   localparam int PRESCALE_W = 10;

   // -------------------------------------------------------------
   // waveform modes that shape the count sequence
   // -------------------------------------------------------------
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_PC_CAPTOP_A = 4'h8;
   localparam logic [3:0] WGM_PC_CAPTOP_B = 4'ha;
   localparam logic [3:0] WGM_CTC_CAPTOP = 4'hc;
   localparam logic [3:0] WGM_FAST_CAPTOP = 4'he;

   // noise filter depth
   localparam int FILTER_DEPTH = 4;

   // direction of a dual-slope count
   typedef enum logic {TCC_DIR_UP = 1'b0, TCC_DIR_DOWN = 1'b1} tcc_dir_t;
endpackage

/* File: design/tcc_noise_filter.sv */
// module: four-sample noise filter in front of the capture edge detector
`timescale 1ns/1ps
`default_nettype none
module tcc_noise_filter
   import tcc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic filter_en,
   input wire logic sample_in,
   output logic level_out
);
   logic [FILTER_DEPTH-1:0] hist_r;
   logic [FILTER_DEPTH-1:0] hist_nxt;
   logic level_r;
   logic level_nxt;

   // -------------------------------------------------------------
   // sampling on the system clock, never on the timer tick
   // -------------------------------------------------------------
   // the bypass path still costs one flop so the filter adds exactly four cycles
   always_comb
   begin
      hist_nxt = {hist_r[FILTER_DEPTH-2:0], sample_in};
      level_nxt = level_r;
      if (!filter_en)
      begin
         level_nxt = sample_in;
      end
      else if (hist_r == {FILTER_DEPTH{hist_r[FILTER_DEPTH-1]}})
      begin
         level_nxt = hist_r[FILTER_DEPTH-1];
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hist_r <= '0;
         level_r <= 1'b0;
      end
      else
      begin
         hist_r <= hist_nxt;
         level_r <= level_nxt;
      end
   end

   assign level_out = level_r;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   filter_agree_a: assert property ((filter_en && $past(filter_en) && level_r != $past(level_r)) |->
      $past(hist_r) == {FILTER_DEPTH{level_r}}) else $error("filter changed without four equal samples");
   filter_bypass_a: assert property (!filter_en |=> level_r == $past(sample_in))
      else $error("bypassed filter did not follow its input");
endmodule
`default_nettype wire

/* File: sim/tcc_cpu_model.sv */
// processor core model: byte-wide register master of the counter
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   // bus idle at time zero, strobes low
   initial
   begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one-cycle write; data inverted when released so stale data never looks valid
   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // one-cycle read, data taken in the following cycle only
   task automatic rd8(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // word writes go high byte first so the latch holds it when low lands
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr8(a + 4'h1, v[15:8]);
      wr8(a, v[7:0]);
   endtask
   // word reads go low byte first so the latch is fresh for the high read
   // the two reads go back to back, strobe held high across both
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_addr <= a + 4'h1;
      #1;
      v[7:0] = reg_rdata;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v[15:8] = reg_rdata;
   endtask
endmodule
`default_nettype wire

/* File: sim/tcc_counter_capture_test.sv */
// testbench: counter access, capture timing and trigger sources
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tcc_counter_capture_test import tcc_pkg::*;;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic pin = 1'b0;
   logic pdrv = 1'b0;
   logic pval = 1'b0;
   logic cmp = 1'b0;
   logic ack = 1'b0;
   logic ext = 1'b0;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   logic cap_irq;
   logic at_bottom;
   logic at_top;
   logic ovf_irq;
   int error_cnt = 0;
   int checks = 0;
   always #2 clk = ~clk;
   tcc_cpu_model cpu (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
   // overflow ack is left idle here; software clears that flag instead
   tcc_counter_capture tcc_counter_capture_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .capture_pin(pin), .capture_port_drive(pdrv),
      .capture_port_value(pval), .comparator_output(cmp), .external_tick_pin(ext), .capture_irq_ack(ack),
      .overflow_irq_ack(1'b0), .capture_irq_req(cap_irq), .overflow_irq_req(ovf_irq), .count_at_top(at_top),
      .count_at_bottom(at_bottom));
   task test_done;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // counts cycles until the capture request rises; a hang ends the run
   task wait_irq(output int n);
      n = 0;
      while (cap_irq !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > 40)
         begin
            error_cnt++;
            test_done();
         end
      end
   endtask
   task test_count;
      logic [15:0] v1, v2;
      cpu.wr16(ADDR_COUNT_LOW, 16'h0000);
      #1 `CHK(at_bottom, 1'b1)
      cpu.wr8(ADDR_CTRL_B, {5'h00, TICK_DIV1});
      repeat (20) @(posedge clk);
      cpu.wr8(ADDR_CTRL_B, 8'h00);
      cpu.rd16(ADDR_COUNT_LOW, v1);
      `CHK(v1, 16'h0016)
      repeat (10) @(posedge clk);
      cpu.rd16(ADDR_COUNT_LOW, v2);
      `CHK(v2, v1)
      `CHK(at_bottom, 1'b0)
      cpu.wr16(ADDR_COUNT_LOW, 16'h0abc);
      cpu.rd16(ADDR_COUNT_LOW, v1);
      `CHK(v1, 16'h0abc)
      $display("count test done");
   endtask
   task test_capture;
      int n0, n1;
      logic [15:0] v;
      cpu.wr8(ADDR_IRQ_MASK, 8'h20);
      cpu.wr8(ADDR_CTRL_B, 8'h40);
      @(posedge clk);
      pin <= 1'b1;
      wait_irq(n0);
      cpu.rd16(ADDR_CAPTURE_LOW, v);
      `CHK(v, 16'h0abc)
      cpu.wr8(ADDR_FLAGS, 8'h20);
      #1 `CHK(cap_irq, 1'b0)
      @(posedge clk);
      pin <= 1'b0;
      repeat (20) @(posedge clk);
      #1 `CHK(cap_irq, 1'b0)
      // same rising edge again, now through the filter
      cpu.wr8(ADDR_CTRL_B, 8'hc0);
      @(posedge clk);
      pin <= 1'b1;
      wait_irq(n1);
      `CHK(n1 - n0, 4)
      cpu.wr16(ADDR_CAPTURE_LOW, 16'h5555);
      cpu.rd16(ADDR_CAPTURE_LOW, v);
      `CHK(v, 16'h0abc)
      $display("capture test done");
   endtask
   task test_sources;
      int n;
      logic [15:0] v;
      cpu.wr8(ADDR_COMP_CTRL, 8'h04);
      cpu.wr8(ADDR_FLAGS, 8'h20);
      cpu.wr16(ADDR_COUNT_LOW, 16'h1357);
      @(posedge clk);
      cmp <= 1'b1;
      wait_irq(n);
      cpu.rd16(ADDR_CAPTURE_LOW, v);
      `CHK(v, 16'h1357)
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      #1 `CHK(cap_irq, 1'b0)
      // back to the pin, edges made by the port driver
      cpu.wr8(ADDR_COMP_CTRL, 8'h00);
      cpu.wr16(ADDR_COUNT_LOW, 16'h2468);
      @(posedge clk);
      pdrv <= 1'b1;
      repeat (20) @(posedge clk);
      cpu.wr8(ADDR_FLAGS, 8'h20);
      pval <= 1'b1;
      wait_irq(n);
      cpu.rd16(ADDR_CAPTURE_LOW, v);
      `CHK(v, 16'h2468)
      $display("source test done");
   endtask
   // capture-as-top mode, clear at top, overflow, external ticks, dual slope
   task test_modes;
      logic [15:0] v;
      cpu.wr8(ADDR_CTRL_B, 8'h18);
      cpu.wr8(ADDR_FLAGS, 8'h20);
      cpu.wr8(ADDR_COUNT_HIGH, 8'h55);
      cpu.wr8(ADDR_COUNT_LOW, 8'h66);
      cpu.wr8(ADDR_CAPTURE_LOW, 8'h77);
      cpu.rd16(ADDR_CAPTURE_LOW, v);
      `CHK(v, 16'h5577)
      cpu.rd16(ADDR_COUNT_LOW, v);
      `CHK(v, 16'h5566)
      pval <= 1'b0;
      repeat (20) @(posedge clk);
      #1 `CHK(cap_irq, 1'b0)
      cpu.wr16(ADDR_COUNT_LOW, 16'h5577);
      #1 `CHK(at_top, 1'b1)
      cpu.wr8(ADDR_CTRL_B, 8'h19);
      cpu.wr8(ADDR_CTRL_B, 8'h18);
      cpu.rd16(ADDR_COUNT_LOW, v);
      `CHK(v, 16'h0001)
      // normal mode wrap past max raises overflow
      cpu.wr8(ADDR_CTRL_B, 8'h00);
      cpu.wr16(ADDR_COUNT_LOW, 16'hfffe);
      cpu.wr8(ADDR_IRQ_MASK, 8'h21);
      cpu.wr8(ADDR_CTRL_B, {5'h00, TICK_DIV1});
      cpu.wr8(ADDR_CTRL_B, 8'h00);
      #1 `CHK(ovf_irq, 1'b1)
      cpu.rd16(ADDR_COUNT_LOW, v);
      `CHK(v, 16'h0000)
      `CHK(at_bottom, 1'b1)
      cpu.wr8(ADDR_FLAGS, 8'h01);
      #1 `CHK(ovf_irq, 1'b0)
      // three rising edges on the external tick pin
      cpu.wr8(ADDR_CTRL_B, {5'h00, TICK_EXT_RISE});
      repeat (6)
      begin
         repeat (10) @(posedge clk);
         ext <= ~ext;
      end
      repeat (10) @(posedge clk);
      cpu.wr8(ADDR_CTRL_B, 8'h00);
      cpu.rd16(ADDR_COUNT_LOW, v);
      `CHK(v, 16'h0003)
      // dual slope with top 0xff turns down after reaching top
      cpu.wr8(ADDR_CTRL_A, 8'h01);
      cpu.wr16(ADDR_COUNT_LOW, 16'h00ff);
      cpu.wr8(ADDR_CTRL_B, {5'h00, TICK_DIV1});
      cpu.wr8(ADDR_CTRL_B, 8'h00);
      cpu.rd16(ADDR_COUNT_LOW, v);
      `CHK(v, 16'h00fd)
      $display("mode test done");
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      test_count();
      test_capture();
      test_sources();
      test_modes();
      test_done();
   end
endmodule
`default_nettype wire
